/* File: verilog/lpms_pkg.sv */
package lpms_pkg;

  localparam int unsigned LPMS_CLK_MHZ          = 125;
  localparam int unsigned LPMS_IRC_MHZ          = 12;
  localparam int unsigned LPMS_IRC_START_US     = 60;
  localparam int unsigned LPMS_FLASH_START_US   = 100;
  localparam int unsigned LPMS_IRC_WAKE_OSC_CYC = 4;
  localparam int unsigned LPMS_XTAL_WAKE_CYC    = 4096;
  localparam int unsigned LPMS_RST_WAIT_CYC     = 256;
  localparam int unsigned LPMS_IRC_WAKE_CYC =
    (LPMS_IRC_WAKE_OSC_CYC * LPMS_CLK_MHZ + LPMS_IRC_MHZ - 1) / LPMS_IRC_MHZ;
  localparam int unsigned LPMS_IRC_START_CYC =
    LPMS_IRC_START_US * LPMS_CLK_MHZ;
  localparam int unsigned LPMS_FLASH_IRC_CYC =
    LPMS_FLASH_START_US * LPMS_IRC_MHZ;
  localparam int unsigned LPMS_FLASH_START_CYC =
    (LPMS_FLASH_IRC_CYC * LPMS_CLK_MHZ + LPMS_IRC_MHZ - 1) / LPMS_IRC_MHZ;

  localparam int unsigned LPMS_CNT_W  = 16;
  localparam int unsigned LPMS_ADDR_W = 8;
  localparam int unsigned LPMS_DATA_W = 32;
  localparam int unsigned LPMS_NIRQ   = 12;
  localparam int unsigned LPMS_CFG_W  = 5;
  localparam int unsigned LPMS_DIV_W  = 8;

  localparam logic [7:0] LPMS_CFG_OFS  = 8'h00;
  localparam logic [7:0] LPMS_DIV_OFS  = 8'h04;
  localparam logic [7:0] LPMS_STAT_OFS = 8'h08;
  localparam logic [4:0] LPMS_CFG_RST  = 5'h00;
  localparam logic [7:0] LPMS_DIV_RST  = 8'h00;

  typedef enum logic [1:0] {
    LPMS_MODE_SLEEP, LPMS_MODE_DSLEEP, LPMS_MODE_PDOWN, LPMS_MODE_RSVD
  } lpms_mode_e;

  typedef enum logic [3:0] {
    LPMS_RST_HOLD, LPMS_RST_OSC, LPMS_RST_CNT, LPMS_RST_FLASH, LPMS_RUN,
    LPMS_SLEEP, LPMS_DSLEEP, LPMS_PDOWN, LPMS_WAKE_IRC, LPMS_WAKE_CNT,
    LPMS_DPD
  } lpms_state_e;

  typedef struct packed {
    logic       nmi;
    logic [3:0] ext_irq_input;
    logic       gpio;
    logic       wake_on_lan;
    logic       brownout;
    logic       rtc_alarm;
    logic       usb_act;
    logic       can_act;
    logic       wdt_timeout;
  } lpms_wake_s;

  typedef struct packed {
    logic keep_32k;
    logic clk_sel_main;
    logic pll_connect;
    logic pll_en;
    logic main_osc_en;
  } lpms_cfg_s;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic irc_power;
    logic irc_out_en;
    logic main_osc_power;
    logic pll_power;
    logic pll_connect;
    logic clk_sel_main;
    logic flash_power;
    logic flash_access_en;
    logic main_sram_en;
    logic periph_ram_en;
    logic dma_en;
    logic osc32k_power;
    logic core_power;
    logic rtc_clk_en;
    logic wdt_clk_en;
  } lpms_pwr_s;

endpackage

/* File: verilog/lpms_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lpms_top
  import lpms_pkg::*;
#(
  parameter int unsigned IRC_START_CYC   = LPMS_IRC_START_CYC,
  parameter int unsigned FLASH_START_CYC = LPMS_FLASH_START_CYC
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // reset sources
  input  wire logic                   ext_reset_in,
  input  wire logic                   wdt_reset_in,
  input  wire logic                   bod_reset_in,
  // oscillator and flash status
  input  wire logic                   irc_ready_in,
  input  wire logic                   flash_init_done_in,
  input  wire logic                   rtc_en_in,
  input  wire logic                   wdt_run_in,
  // processor and rtc requests
  input  wire logic                   sleep_req_in,
  input  wire logic [1:0]             mode_sel_in,
  input  wire logic                   rtc_dpd_req_in,
  // interrupt lines and mask from nested_irq_ctrl
  input  wire lpms_wake_s             wake_irq_in,
  input  wire logic [LPMS_NIRQ-1:0]   irq_enable_mask_in,
  // register port
  input  wire logic [LPMS_ADDR_W-1:0] addr_in,
  input  wire logic [LPMS_DATA_W-1:0] wr_data_in,
  input  wire logic                   wr_en_in,
  input  wire logic                   rd_en_in,
  output logic      [LPMS_DATA_W-1:0] rd_data_out,
  // power and clock controls
  output lpms_pwr_s                   pwr_out,
  output logic      [LPMS_DIV_W-1:0]  clk_div_out,
  output logic                        internal_reset_out,
  output logic      [LPMS_NIRQ-1:0]   wake_irq_ctrl_mask_out,
  output logic      [3:0]             state_out
);

  localparam logic [LPMS_CNT_W-1:0] IRC_START_LD =
    LPMS_CNT_W'(IRC_START_CYC - 1);
  localparam logic [LPMS_CNT_W-1:0] FLASH_LD =
    LPMS_CNT_W'(FLASH_START_CYC - 1);
  localparam logic [LPMS_CNT_W-1:0] IRC_WAKE_LD =
    LPMS_CNT_W'(LPMS_IRC_WAKE_CYC - 1);
  localparam logic [LPMS_CNT_W-1:0] XTAL_WAKE_LD =
    LPMS_CNT_W'(LPMS_XTAL_WAKE_CYC - 1);
  localparam logic [LPMS_CNT_W-1:0] RST_WAIT_LD =
    LPMS_CNT_W'(LPMS_RST_WAIT_CYC - 1);

  lpms_state_e            state_reg;
  lpms_state_e            state_next;
  logic [LPMS_CNT_W-1:0]  cnt_reg;
  logic [LPMS_CNT_W-1:0]  cnt_next;
  logic [LPMS_CNT_W-1:0]  flash_cnt_reg;
  logic                   flash_ready_reg;
  lpms_cfg_s              cfg_reg;
  logic [LPMS_DIV_W-1:0]  div_reg;
  logic [LPMS_NIRQ-1:0]   wic_mask_reg;
  logic                   used_main_reg;
  logic [LPMS_NIRQ-1:0]   wake_bits;
  logic                   reset_any;
  logic                   live_hit;
  logic                   wic_hit;
  logic                   enter_deep;
  logic                   enter_pd;
  logic                   flash_off;

  ////////////////////////////////////////////////////////////////////////
  // wake decode

  assign wake_bits = wake_irq_in;
  assign reset_any = ext_reset_in | wdt_reset_in | bod_reset_in;
  // nmi cannot be masked off
  assign live_hit = (|(wake_bits & irq_enable_mask_in)) |
                    wake_irq_in.nmi;
  assign wic_hit = (|(wake_bits & wic_mask_reg)) |
                   wake_irq_in.nmi;

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
    if (reset_any) begin
      state_next = LPMS_RST_HOLD;
      cnt_next   = RST_WAIT_LD;
    end else begin
      unique case (state_reg)
        LPMS_RST_HOLD: begin
          state_next = LPMS_RST_OSC;
          cnt_next   = RST_WAIT_LD;
        end
        LPMS_RST_OSC: begin
          cnt_next = RST_WAIT_LD;
          if (irc_ready_in) begin
            state_next = LPMS_RST_CNT;
          end
        end
        LPMS_RST_CNT: begin
          if (cnt_reg == '0) begin
            state_next = LPMS_RST_FLASH;
          end
        end
        LPMS_RST_FLASH: begin
          if (flash_ready_reg && flash_init_done_in) begin
            state_next = LPMS_RUN;
          end
        end
        LPMS_RUN: begin
          if (rtc_dpd_req_in) begin
            state_next = LPMS_DPD;
          end else if (sleep_req_in) begin
            unique case (lpms_mode_e'(mode_sel_in))
              LPMS_MODE_SLEEP:  state_next = LPMS_SLEEP;
              LPMS_MODE_DSLEEP: state_next = LPMS_DSLEEP;
              LPMS_MODE_PDOWN:  state_next = LPMS_PDOWN;
              LPMS_MODE_RSVD:   state_next = LPMS_RUN;
            endcase
          end
        end
        LPMS_SLEEP: begin
          if (live_hit) begin
            state_next = LPMS_RUN;
          end
        end
        LPMS_DSLEEP: begin
          if (wic_hit) begin
            state_next = LPMS_WAKE_CNT;
            cnt_next   = used_main_reg ? XTAL_WAKE_LD
                                       : IRC_WAKE_LD;
          end
        end
        LPMS_PDOWN: begin
          if (wic_hit) begin
            state_next = LPMS_WAKE_IRC;
            cnt_next   = IRC_START_LD;
          end
        end
        LPMS_WAKE_IRC: begin
          if (cnt_reg == '0) begin
            state_next = LPMS_WAKE_CNT;
            cnt_next   = IRC_WAKE_LD;
          end
        end
        LPMS_WAKE_CNT: begin
          if (cnt_reg == '0) begin
            state_next = LPMS_RUN;
          end
        end
        LPMS_DPD: begin
          if (wake_irq_in.rtc_alarm) begin
            state_next = LPMS_RST_HOLD;
          end
        end
        default: begin
          state_next = LPMS_RST_HOLD;
        end
      endcase
    end
  end

  assign enter_deep = (state_reg == LPMS_RUN) &&
                      ((state_next == LPMS_DSLEEP) ||
                       (state_next == LPMS_PDOWN) ||
                       (state_next == LPMS_DPD));
  assign enter_pd = (state_reg == LPMS_RUN) &&
                    ((state_next == LPMS_PDOWN) ||
                     (state_next == LPMS_DPD));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= LPMS_RST_HOLD;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mask latch for wake_irq_ctrl

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wic_mask_reg  <= '0;
      used_main_reg <= 1'b0;
    end else if (enter_deep) begin
      wic_mask_reg  <= irq_enable_mask_in;
      used_main_reg <= cfg_reg.clk_sel_main;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash wake-up timer

  assign flash_off = (state_reg == LPMS_PDOWN) ||
                     (state_reg == LPMS_DPD) ||
                     (state_reg == LPMS_RST_HOLD);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_cnt_reg   <= FLASH_LD;
      flash_ready_reg <= 1'b0;
    end else if (flash_off) begin
      flash_cnt_reg   <= FLASH_LD;
      flash_ready_reg <= 1'b0;
    end else begin
      if (flash_cnt_reg != '0) begin
        flash_cnt_reg <= flash_cnt_reg - 1'b1;
      end
      flash_ready_reg <= (flash_cnt_reg == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock configuration registers: divider and PLL bits cleared by hardware on deep entry, clk_sel_main on power-down entry

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg <= lpms_cfg_s'(LPMS_CFG_RST);
    end else if (reset_any) begin
      cfg_reg <= lpms_cfg_s'(LPMS_CFG_RST);
    end else if (enter_deep) begin
      cfg_reg.pll_en      <= 1'b0;
      cfg_reg.pll_connect <= 1'b0;
      if (enter_pd) begin
        cfg_reg.clk_sel_main <= 1'b0;
      end
    end else if (wr_en_in && addr_in == LPMS_CFG_OFS) begin
      cfg_reg <= lpms_cfg_s'(wr_data_in[LPMS_CFG_W-1:0]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= LPMS_DIV_RST;
    end else if (reset_any || enter_deep) begin
      div_reg <= LPMS_DIV_RST;
    end else if (wr_en_in && addr_in == LPMS_DIV_OFS) begin
      div_reg <= wr_data_in[LPMS_DIV_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else if (rd_en_in) begin
      unique case (addr_in)
        LPMS_CFG_OFS:  rd_data_out <= {27'h0000000, cfg_reg};
        LPMS_DIV_OFS:  rd_data_out <= {24'h000000, div_reg};
        LPMS_STAT_OFS: rd_data_out <= {25'h0000000, used_main_reg,
                                       internal_reset_out,
                                       flash_ready_reg, state_reg};
        default:       rd_data_out <= '0;
      endcase
    end else begin
      rd_data_out <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power and clock controls per state

  function automatic lpms_pwr_s pwr_of(input lpms_state_e st,
                                       input lpms_cfg_s   cfg,
                                       input logic        fl_rdy);
    lpms_pwr_s p;
    p.core_clk_en     = 1'b1;
    p.periph_clk_en   = 1'b1;
    p.irc_power       = 1'b1;
    p.irc_out_en      = 1'b1;
    p.main_osc_power  = cfg.main_osc_en;
    p.pll_power       = cfg.pll_en;
    p.pll_connect     = cfg.pll_en & cfg.pll_connect;
    p.clk_sel_main    = cfg.clk_sel_main;
    p.flash_power     = 1'b1;
    p.flash_access_en = fl_rdy;
    p.main_sram_en    = 1'b1;
    p.periph_ram_en   = 1'b1;
    p.dma_en          = 1'b1;
    p.osc32k_power    = 1'b1;
    p.core_power      = 1'b1;
    p.rtc_clk_en      = rtc_en_in;
    p.wdt_clk_en      = wdt_run_in;
    unique case (st)
      LPMS_RUN: begin
      end
      LPMS_SLEEP: begin
        p.core_clk_en     = 1'b0;
        p.flash_access_en = 1'b0;
        p.main_sram_en    = 1'b0;
      end
      LPMS_DSLEEP, LPMS_PDOWN: begin
        p.core_clk_en     = 1'b0;
        p.periph_clk_en   = 1'b0;
        p.irc_out_en      = 1'b0;
        p.main_osc_power  = 1'b0;
        p.pll_power       = 1'b0;
        p.pll_connect     = 1'b0;
        p.flash_access_en = 1'b0;
        p.main_sram_en    = 1'b0;
        p.periph_ram_en   = 1'b0;
        p.dma_en          = 1'b0;
        if (st == LPMS_PDOWN) begin
          p.irc_power    = 1'b0;
          p.flash_power  = 1'b0;
          p.clk_sel_main = 1'b0;
        end
      end
      LPMS_DPD: begin
        p = '0;
        p.osc32k_power = cfg.keep_32k;
        p.rtc_clk_en   = rtc_en_in & cfg.keep_32k;
      end
      default: begin
        // reset and wake sequences: core held, on the RC with its output gated in LPMS_WAKE_IRC; LPMS_WAKE_CNT follows clk_sel_main
        p.core_clk_en     = 1'b0;
        p.periph_clk_en   = 1'b0;
        p.flash_access_en = 1'b0;
        p.pll_power       = 1'b0;
        p.pll_connect     = 1'b0;
        p.clk_sel_main    = (st == LPMS_WAKE_CNT) & cfg.clk_sel_main;
        p.irc_out_en      = (st != LPMS_WAKE_IRC);
        if (st == LPMS_WAKE_IRC || st == LPMS_WAKE_CNT) begin
          p.main_sram_en = 1'b1;
        end
      end
    endcase
    return p;
  endfunction

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_out <= '0;
    end else begin
      pwr_out <= pwr_of(state_next, cfg_reg, flash_ready_reg);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      internal_reset_out     <= 1'b1;
      state_out              <= 4'h0;
      clk_div_out            <= LPMS_DIV_RST;
      wake_irq_ctrl_mask_out <= '0;
    end else begin
      internal_reset_out <= (state_next == LPMS_RST_HOLD) ||
                            (state_next == LPMS_RST_OSC) ||
                            (state_next == LPMS_RST_CNT) ||
                            (state_next == LPMS_RST_FLASH);
      state_out              <= state_next;
      clk_div_out            <= (reset_any || enter_deep) ? LPMS_DIV_RST :
                                div_reg;
      wake_irq_ctrl_mask_out <= wic_mask_reg;
    end
  end

endmodule
`default_nettype wire

/* File: sim/lpms_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpms_cpu_model
  import lpms_pkg::*;
(
  // clock and device status
  input  wire logic            clk_in,
  input  wire logic            internal_reset_in,
  // requests to the sequencer
  output logic                 sleep_req_out,
  output logic [1:0]           mode_sel_out,
  output logic [LPMS_NIRQ-1:0] irq_mask_out
);
  initial begin
    sleep_req_out = 1'b0;
    mode_sel_out  = 2'h0;
    irq_mask_out  = '0;
  end
  ////////////////////////////////////////////////////////////
  // the core asks for a power state only once out of reset
  task automatic enter(input logic [1:0] m);
    while (internal_reset_in !== 1'b0) @(posedge clk_in);
    @(posedge clk_in);
    sleep_req_out <= 1'b1;
    mode_sel_out  <= m;
    @(posedge clk_in);
    sleep_req_out <= 1'b0;
    mode_sel_out  <= ~m;
  endtask
  // enabled and priority-qualified lines of nested_irq_ctrl
  task automatic set_mask(input logic [LPMS_NIRQ-1:0] m);
    @(posedge clk_in);
    irq_mask_out <= m;
  endtask
endmodule
`default_nettype wire

/* File: sim/lpms_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lpms_top_properties
  import lpms_pkg::*;
#(
  parameter int unsigned IRC_START_CYC   = LPMS_IRC_START_CYC,
  parameter int unsigned FLASH_START_CYC = LPMS_FLASH_START_CYC
) (
  // clock and reset
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  // reset sources and oscillator
  input wire logic                  ext_reset_in,
  input wire logic                  wdt_reset_in,
  input wire logic                  bod_reset_in,
  input wire logic                  irc_ready_in,
  // requests and interrupts
  input wire logic                  sleep_req_in,
  input wire logic [1:0]            mode_sel_in,
  input wire logic                  rtc_dpd_req_in,
  input wire lpms_wake_s            wake_irq_in,
  input wire logic [LPMS_NIRQ-1:0]  irq_enable_mask_in,
  // observed outputs
  input wire lpms_pwr_s             pwr_out,
  input wire logic [LPMS_DIV_W-1:0] clk_div_out,
  input wire logic                  internal_reset_out,
  input wire logic [LPMS_NIRQ-1:0]  wake_irq_ctrl_mask_out,
  input wire logic [3:0]            state_out
);
  logic [3:0]           prev_st;
  logic [15:0]          dwell;
  logic                 main_sel;
  logic                 rsrc;
  logic                 go;
  logic [LPMS_NIRQ-1:0] wake_v;
  assign rsrc   = ext_reset_in | wdt_reset_in | bod_reset_in;
  assign wake_v = wake_irq_in;
  assign go     = state_out == LPMS_RUN && sleep_req_in && !rtc_dpd_req_in
                  && !rsrc;
  // dwell counts the cycles spent in the current state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_st  <= 4'h0;
      dwell    <= 16'h0000;
      main_sel <= 1'b0;
    end else begin
      prev_st <= state_out;
      dwell   <= (state_out == prev_st) ? dwell + 16'h0001 : 16'h0001;
      if (state_out == LPMS_RUN) main_sel <= pwr_out.clk_sel_main;
      else if (state_out == LPMS_PDOWN) main_sel <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_sleep_core_off: assert property (
    go && mode_sel_in == 2'h0 |=> state_out == LPMS_SLEEP
    && !pwr_out.core_clk_en && pwr_out.periph_clk_en && pwr_out.dma_en
    && !pwr_out.main_sram_en && !pwr_out.flash_access_en)
    else $error("sleep entry outputs wrong");
  a_sleep_irq_wake: assert property (
    state_out == LPMS_SLEEP && !rsrc && |(wake_v & irq_enable_mask_in)
    |=> state_out == LPMS_RUN) else $error("sleep did not wake");
  a_dsleep_pll_off: assert property (
    go && mode_sel_in == 2'h1 |=> state_out == LPMS_DSLEEP
    && !pwr_out.pll_power && !pwr_out.pll_connect && clk_div_out == 8'h00
    && pwr_out.flash_power && pwr_out.irc_power && !pwr_out.irc_out_en)
    else $error("deep-sleep entry outputs wrong");
  a_pdown_all_off: assert property (
    go && mode_sel_in == 2'h2 |=> state_out == LPMS_PDOWN
    && !pwr_out.irc_power && !pwr_out.flash_power && !pwr_out.clk_sel_main
    && !pwr_out.pll_power && clk_div_out == 8'h00)
    else $error("power-down entry outputs wrong");
  a_mask_latch: assert property (
    go && mode_sel_in inside {2'h1, 2'h2} |=> ##1
    wake_irq_ctrl_mask_out == $past(irq_enable_mask_in, 2))
    else $error("wake mask not latched");
  a_mode_refused: assert property (
    go && mode_sel_in == 2'h3 |=> state_out == LPMS_RUN)
    else $error("reserved mode entered a state");
  a_wake_count: assert property (
    prev_st == LPMS_WAKE_CNT && state_out != LPMS_WAKE_CNT && !$past(rsrc)
    |-> state_out == LPMS_RUN && dwell == (main_sel ? 16'h1000 : 16'h002A))
    else $error("wake count wrong");
  a_irc_start: assert property (
    prev_st == LPMS_WAKE_IRC && state_out != LPMS_WAKE_IRC && !$past(rsrc)
    |-> state_out == LPMS_WAKE_CNT && dwell == 16'(IRC_START_CYC))
    else $error("rc start-up wait wrong");
  a_rst_count: assert property (
    prev_st == LPMS_RST_CNT && state_out != LPMS_RST_CNT && !$past(rsrc)
    |-> dwell == 16'h0100) else $error("reset count wrong");
  a_osc_hold: assert property (
    state_out == LPMS_RST_OSC && !irc_ready_in && !rsrc
    |=> state_out == LPMS_RST_OSC && internal_reset_out)
    else $error("left oscillator wait early");
  a_reset_source: assert property (
    rsrc |=> internal_reset_out && state_out == LPMS_RST_HOLD)
    else $error("reset source ignored");
  a_irc_clock: assert property (
    prev_st == LPMS_RST_FLASH && state_out == LPMS_RUN
    |-> !pwr_out.clk_sel_main && pwr_out.irc_out_en && !internal_reset_out)
    else $error("not on rc clock after reset");
  a_dpd_entry: assert property (
    state_out == LPMS_RUN && rtc_dpd_req_in && !rsrc |=> state_out == LPMS_DPD
    && !pwr_out.core_power && !pwr_out.flash_power && !pwr_out.irc_power)
    else $error("deep power-down entry wrong");
  a_dpd_stay: assert property (
    state_out == LPMS_DPD && !rsrc && !wake_irq_in.rtc_alarm
    |=> state_out == LPMS_DPD) else $error("left deep power-down");
  c_sleep_wake: cover property (
    state_out == LPMS_SLEEP ##1 state_out == LPMS_RUN);
  c_main_wake: cover property (
    prev_st == LPMS_WAKE_CNT && state_out == LPMS_RUN && main_sel);
  c_dpd_exit: cover property (
    state_out == LPMS_DPD ##1 state_out == LPMS_RST_HOLD);
endmodule
bind lpms_top lpms_top_properties #(
  .IRC_START_CYC(IRC_START_CYC), .FLASH_START_CYC(FLASH_START_CYC)
) u_lpms_top_properties (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_in(ext_reset_in),
  .wdt_reset_in(wdt_reset_in), .bod_reset_in(bod_reset_in),
  .irc_ready_in(irc_ready_in), .sleep_req_in(sleep_req_in),
  .mode_sel_in(mode_sel_in), .rtc_dpd_req_in(rtc_dpd_req_in),
  .wake_irq_in(wake_irq_in), .irq_enable_mask_in(irq_enable_mask_in),
  .pwr_out(pwr_out), .clk_div_out(clk_div_out),
  .internal_reset_out(internal_reset_out),
  .wake_irq_ctrl_mask_out(wake_irq_ctrl_mask_out), .state_out(state_out));
`default_nettype wire

/* File: sim/lpms_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module lpms_top_bench
  import lpms_pkg::*;
;
  localparam int IRC_N = 20;
  logic                   clk, rst_n, irc_rdy, fl_done, rtc_en, wdt_run;
  logic                   dpd_req, wr, rd, int_rst, sreq;
  logic [2:0]             rsrc;
  lpms_wake_s             wake;
  logic [LPMS_ADDR_W-1:0] addr;
  logic [LPMS_DATA_W-1:0] wdata, rdata;
  logic [1:0]             msel;
  logic [LPMS_NIRQ-1:0]   mask, wmask;
  lpms_pwr_s              pwr;
  logic [LPMS_DIV_W-1:0]  div;
  logic [3:0]             st;
  int                     err_total, checked;
  lpms_top #(.IRC_START_CYC(IRC_N), .FLASH_START_CYC(40)) u_lpms_top (
    .clk_in(clk), .rst_n_in(rst_n), .ext_reset_in(rsrc[0]),
    .wdt_reset_in(rsrc[1]), .bod_reset_in(rsrc[2]), .irc_ready_in(irc_rdy),
    .flash_init_done_in(fl_done), .rtc_en_in(rtc_en), .wdt_run_in(wdt_run),
    .sleep_req_in(sreq), .mode_sel_in(msel), .rtc_dpd_req_in(dpd_req),
    .wake_irq_in(wake), .irq_enable_mask_in(mask), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata),
    .pwr_out(pwr), .clk_div_out(div), .internal_reset_out(int_rst),
    .wake_irq_ctrl_mask_out(wmask), .state_out(st));
  lpms_cpu_model u_lpms_cpu_model (.clk_in(clk), .internal_reset_in(int_rst),
    .sleep_req_out(sreq), .mode_sel_out(msel), .irq_mask_out(mask));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  function automatic logic [5:0] pb();
    return {pwr.core_clk_en, pwr.periph_clk_en, pwr.dma_en,
            pwr.periph_ram_en, pwr.main_sram_en, pwr.flash_access_en};
  endfunction
  function automatic logic [5:0] qb();
    return {pwr.core_clk_en, pwr.irc_power, pwr.irc_out_en,
            pwr.pll_power, pwr.pll_connect, pwr.flash_power};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    int n;
    n = 0;
    while (st !== s && n < lim) begin
      tick(1);
      n++;
    end
    `CHK(st, s)
  endtask
  // counts whole cycles spent in state s
  task automatic dwell(input logic [3:0] s, input int e);
    int n;
    n = 0;
    wait_st(s, 8);
    while (st === s && n < 9000) begin
      tick(1);
      n++;
    end
    `CHK(n, e)
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_n, irc_rdy, fl_done, rtc_en, wdt_run, dpd_req} = 7'h00;
    {wr, rd, rsrc, addr, wdata} = '0;
    wake = '0;
    err_total = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    `CHK({int_rst, pwr}, {1'b1, lpms_pwr_s'(0)})
    rst_n <= 1'b1;
    tick(10);
    `CHK(st, 4'(LPMS_RST_OSC))
    @(posedge clk) irc_rdy <= 1'b1;
    tick(300);
    `CHK({int_rst, st}, {1'b1, 4'(LPMS_RST_FLASH)})
    @(posedge clk) fl_done <= 1'b1;
    wait_st(LPMS_RUN, 8);
    `CHK({pwr.clk_sel_main, pwr.irc_out_en, int_rst}, 3'b010)
    rd_reg(LPMS_CFG_OFS, 32'(LPMS_CFG_RST));
    rd_reg(LPMS_DIV_OFS, 32'(LPMS_DIV_RST));
    wr_reg(LPMS_STAT_OFS, 32'hFFFFFFFF);
    wr_reg(8'h0C, 32'h000000FF);
    rd_reg(LPMS_STAT_OFS, 32'h00000014);
    rd_reg(8'h0C, 32'h00000000);
    u_lpms_cpu_model.set_mask(12'h001);
    u_lpms_cpu_model.enter(2'h0);
    tick(1);
    `CHK(pb(), 6'b011100)
    @(posedge clk) wake <= lpms_wake_s'(12'h040);
    tick(3);
    `CHK(st, 4'(LPMS_SLEEP))
    @(posedge clk) wake <= lpms_wake_s'(12'h001);
    tick(2);
    `CHK(st, 4'(LPMS_RUN))
    @(posedge clk) wake <= '0;
    u_lpms_cpu_model.enter(2'h3);
    tick(2);
    `CHK(st, 4'(LPMS_RUN))
    for (int i = 0; i < 2; i++) begin
      wr_reg(LPMS_CFG_OFS, 32'h07);
      wr_reg(LPMS_CFG_OFS, i ? 32'h1F : 32'h07);
      wr_reg(LPMS_DIV_OFS, 32'h5A);
      u_lpms_cpu_model.set_mask(12'h080);
      u_lpms_cpu_model.enter(2'h1);
      u_lpms_cpu_model.set_mask(12'h000);
      tick(1);
      `CHK(st, 4'(LPMS_DSLEEP))
      `CHK({qb(), div}, {6'b010001, 8'h00})
      `CHK(wmask, 12'h080)
      @(posedge clk) wake <= lpms_wake_s'(i ? 12'h080 : 12'h800);
      dwell(LPMS_WAKE_CNT, i ? 4096 : 42);
      @(posedge clk) wake <= '0;
      rd_reg(LPMS_CFG_OFS, i ? 32'h19 : 32'h01);
    end
    @(posedge clk) rtc_en <= 1'b1;
    wdt_run <= 1'b1;
    wr_reg(LPMS_DIV_OFS, 32'h33);
    u_lpms_cpu_model.set_mask(12'h008);
    u_lpms_cpu_model.enter(2'h2);
    tick(1);
    `CHK({st, qb(), pwr.clk_sel_main}, {4'(LPMS_PDOWN), 7'h00})
    `CHK({pwr.rtc_clk_en, pwr.wdt_clk_en, div}, 10'h300)
    @(posedge clk) wake <= lpms_wake_s'(12'h008);
    dwell(LPMS_WAKE_IRC, IRC_N);
    `CHK(pwr.flash_access_en, 1'b0)
    dwell(LPMS_WAKE_CNT, 42);
    `CHK({pwr.flash_access_en, pwr.irc_out_en}, 2'b11)
    @(posedge clk) wake <= '0;
    for (int i = 0; i < 2; i++) begin
      wr_reg(LPMS_CFG_OFS, i ? 32'h10 : 32'h00);
      @(posedge clk) dpd_req <= 1'b1;
      @(posedge clk) dpd_req <= 1'b0;
      tick(1);
      `CHK(st, 4'(LPMS_DPD))
      `CHK({pwr.core_power, pwr.osc32k_power}, {1'b0, i[0]})
      @(posedge clk) wake <= lpms_wake_s'(12'h800);
      tick(3);
      `CHK(st, 4'(LPMS_DPD))
      @(posedge clk) wake <= lpms_wake_s'(i ? 12'h008 : 12'h000);
      rsrc <= i ? 3'h0 : 3'h1;
      tick(2);
      `CHK(int_rst, 1'b1)
      @(posedge clk) wake <= '0;
      rsrc <= 3'h0;
      wait_st(LPMS_RUN, 400);
    end
    for (int k = 0; k < 3; k++) begin
      wr_reg(LPMS_DIV_OFS, 32'h44);
      @(posedge clk) rsrc <= 3'(1 << k);
      {irc_rdy, fl_done, rtc_en, wdt_run} <= {2'b00, k[0], ~k[0]};
      @(posedge clk) rsrc <= 3'h0;
      tick(6);
      `CHK({int_rst, st}, {1'b1, 4'(LPMS_RST_OSC)})
      @(posedge clk) {irc_rdy, fl_done} <= 2'b11;
      wait_st(LPMS_RUN, 400);
      `CHK({pwr.rtc_clk_en, pwr.wdt_clk_en}, {k[0], ~k[0]})
      rd_reg(LPMS_DIV_OFS, 32'h00);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
